// *** src/tmcap_pkg.sv ***
// Constants, register map and carrier types of the 16-bit timer counter and capture block
// What this block does
// - Clock select zero stops the tick; other codes pick the tick source.
// - Each tick clears, increments or decrements the 16-bit counter per mode.
// - Bottom indication at zero, top indication at the sequence maximum.
// - Counter high location is the shared latch; low-byte read loads it.
// - Counter low-byte write loads the high byte from the latch together.
// - Software reads and writes the counter whether or not ticks arrive.
// - A software counter write beats any clear or count in that cycle.
// - Waveform mode bits, split over control A and B, set the sequence.
// - Overflow flag sets where the mode says and can request an interrupt.
// - Capture source is the pin, or the comparator when selected.
// - A matching edge copies the counter to capture and sets its flag.
// - Enabled capture flag requests interrupt; service or write-one clears it.
// - Capture low-byte read loads the latch; high location returns the latch.
// - Capture register is writable only when it serves as the top value.
// - Changing the source may capture falsely; software clears the flag after.
// - Both inputs synchronised like the external pin; filter adds four cycles.
// - Filter output changes only after four agreeing system-clock samples.
// - Filter and edge detector always on, except capture-as-top modes.
// - Every new capture overwrites the capture register.
// - Software driving the capture pin's port captures like an external event.
// - All 16-bit registers share one high-byte latch.
// - Top is 0xFFFF, 0x00FF, 0x01FF, 0x03FF, compare A or capture, by mode.
package tmcap_pkg;

  // ********************************
  // Register offsets
  // ********************************
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CNT_LO = 8'h08;
  localparam logic [7:0] OFS_CNT_HI = 8'h0C;
  localparam logic [7:0] OFS_CAP_LO = 8'h10;
  localparam logic [7:0] OFS_CAP_HI = 8'h14;
  localparam logic [7:0] OFS_CMPA_LO = 8'h18;
  localparam logic [7:0] OFS_CMPA_HI = 8'h1C;
  localparam logic [7:0] OFS_FLAGS = 8'h20;
  localparam logic [7:0] OFS_IRQ_EN = 8'h24;
  localparam logic [7:0] OFS_COMP_CTRL = 8'h28;

  // ********************************
  // Field positions
  // ********************************
  localparam int CS_LSB = 0;
  localparam int WGM_HI_LSB = 3;
  localparam int EDGE_SEL_BIT = 6;
  localparam int NOISE_EN_BIT = 7;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CAP_BIT = 1;
  localparam int COMP_SEL_BIT = 0;

  // ********************************
  // Reset values and fixed tops
  // ********************************
  localparam logic [1:0] CTRL_A_RST = 2'h0;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam int FILTER_SAMPLES = 4;

  // ********************************
  // Clock select codes
  // ********************************
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_SYS = 3'h1;
  localparam logic [2:0] CS_PRE_FIRST = 3'h2;
  localparam logic [2:0] CS_PRE_LAST = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // ********************************
  // Carrier types
  // ********************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tmcap_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tmcap_apb_rsp_t;

endpackage

// *** src/tmcap_top.sv ***
// 16-bit timer counter unit with input capture, behind an APB slave
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/100ps
module tmcap_top #(
  parameter int FILTER_LEN = tmcap_pkg::FILTER_SAMPLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire tmcap_pkg::tmcap_apb_req_t apb_req,
  output tmcap_pkg::tmcap_apb_rsp_t apb_rsp,
  input wire logic [3:0] prescale_tick,
  input wire logic external_clock_pin,
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic overflow_irq_ack,
  input wire logic capture_irq_ack,
  output logic overflow_irq,
  output logic capture_irq,
  output logic timer_tick,
  output logic counter_top,
  output logic counter_bottom,
  output logic [3:0] waveform_mode_field,
  output logic [15:0] counter_value
);

  initial begin
    if (FILTER_LEN < 2 || FILTER_LEN > 16) begin
      $error("FILTER_LEN must lie between 2 and 16");
    end
  end

  // ********************************
  // Registers
  // ********************************
  logic [1:0] ctrl_a_r;
  logic [7:0] ctrl_b_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic down_r;
  logic down_nxt;
  logic [7:0] temp_r;
  logic [7:0] snap_hi_r;
  logic [15:0] icr_r;
  logic [15:0] ocra_r;
  logic ovf_flag_r;
  logic cap_flag_r;
  logic ovf_en_r;
  logic cap_en_r;
  logic comp_sel_r;
  logic [2:0] cs;
  logic [3:0] wgm;

  assign cs = ctrl_b_r[tmcap_pkg::CS_LSB +: 3];
  assign wgm = {ctrl_b_r[tmcap_pkg::WGM_HI_LSB +: 2], ctrl_a_r};

  // ********************************
  // APB slave
  // ********************************
  // No wait state: read data is registered at the setup edge so the
  // response port comes from flip-flops.
  logic setup_phase;
  logic acc_done;
  logic wr_done;
  logic rd_done;
  logic [7:0] wbyte;
  logic [7:0] rd_lo;
  logic rd_hit;

  assign setup_phase = apb_req.psel & ~apb_req.penable & ~apb_rsp.pready;
  assign acc_done = apb_req.psel & apb_req.penable & apb_rsp.pready;
  assign wr_done = acc_done & apb_req.pwrite;
  assign rd_done = acc_done & ~apb_req.pwrite;
  assign wbyte = apb_req.pwdata[7:0];

  always_comb begin
    rd_lo = 8'h00;
    rd_hit = 1'b1;
    unique case (apb_req.paddr)
      tmcap_pkg::OFS_CTRL_A: rd_lo = {6'h00, ctrl_a_r};
      tmcap_pkg::OFS_CTRL_B: rd_lo = ctrl_b_r;
      tmcap_pkg::OFS_CNT_LO: rd_lo = cnt_r[7:0];
      tmcap_pkg::OFS_CNT_HI: rd_lo = temp_r;
      tmcap_pkg::OFS_CAP_LO: rd_lo = icr_r[7:0];
      tmcap_pkg::OFS_CAP_HI: rd_lo = temp_r;
      tmcap_pkg::OFS_CMPA_LO: rd_lo = ocra_r[7:0];
      // Compare A is only changed by software, so no latch on reads
      tmcap_pkg::OFS_CMPA_HI: rd_lo = ocra_r[15:8];
      tmcap_pkg::OFS_FLAGS: rd_lo = {6'h00, cap_flag_r, ovf_flag_r};
      tmcap_pkg::OFS_IRQ_EN: rd_lo = {6'h00, cap_en_r, ovf_en_r};
      tmcap_pkg::OFS_COMP_CTRL: rd_lo = {7'h00, comp_sel_r};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      apb_rsp <= '0;
    end else if (setup_phase) begin
      apb_rsp.pready <= 1'b1;
      apb_rsp.pslverr <= ~rd_hit;
      apb_rsp.prdata <= apb_req.pwrite ? 32'h0000_0000 : {24'h00_0000, rd_lo};
    end else begin
      apb_rsp.pready <= 1'b0;
      apb_rsp.pslverr <= 1'b0;
    end
  end

  // Snapshot of the high byte taken with the low byte sampled for prdata
  always_ff @(posedge clk) begin
    if (!resetn) begin
      snap_hi_r <= 8'h00;
    end else if (setup_phase) begin
      snap_hi_r <= (apb_req.paddr == tmcap_pkg::OFS_CAP_LO) ? icr_r[15:8] : cnt_r[15:8];
    end
  end

  // Shared high-byte latch for every 16-bit register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      temp_r <= 8'h00;
    end else if (rd_done && (apb_req.paddr == tmcap_pkg::OFS_CNT_LO ||
                             apb_req.paddr == tmcap_pkg::OFS_CAP_LO)) begin
      temp_r <= snap_hi_r;
    end else if (wr_done && (apb_req.paddr == tmcap_pkg::OFS_CNT_HI ||
                             apb_req.paddr == tmcap_pkg::OFS_CAP_HI ||
                             apb_req.paddr == tmcap_pkg::OFS_CMPA_HI)) begin
      temp_r <= wbyte;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_a_r <= tmcap_pkg::CTRL_A_RST;
      ctrl_b_r <= tmcap_pkg::CTRL_B_RST;
      ovf_en_r <= 1'b0;
      cap_en_r <= 1'b0;
      comp_sel_r <= 1'b0;
      ocra_r <= 16'h0000;
    end else if (wr_done) begin
      if (apb_req.paddr == tmcap_pkg::OFS_CTRL_A) begin
        ctrl_a_r <= wbyte[1:0];
      end
      if (apb_req.paddr == tmcap_pkg::OFS_CTRL_B) begin
        ctrl_b_r <= wbyte;
      end
      if (apb_req.paddr == tmcap_pkg::OFS_IRQ_EN) begin
        ovf_en_r <= wbyte[tmcap_pkg::FLAG_OVF_BIT];
        cap_en_r <= wbyte[tmcap_pkg::FLAG_CAP_BIT];
      end
      if (apb_req.paddr == tmcap_pkg::OFS_COMP_CTRL) begin
        comp_sel_r <= wbyte[tmcap_pkg::COMP_SEL_BIT];
      end
      if (apb_req.paddr == tmcap_pkg::OFS_CMPA_LO) begin
        ocra_r <= {temp_r, wbyte};
      end
    end
  end

  // ********************************
  // Mode decode and top value
  // ********************************
  logic icr_top;
  logic ocra_top;
  logic dual_slope;
  logic fast_pwm;
  logic clear_at_top;
  logic [15:0] top_val;

  always_comb begin
    icr_top = (wgm == 4'h8) || (wgm == 4'hA) || (wgm == 4'hC) || (wgm == 4'hE);
    ocra_top = (wgm == 4'h4) || (wgm == 4'h9) || (wgm == 4'hB) || (wgm == 4'hF);
    dual_slope = (wgm >= 4'h1 && wgm <= 4'h3) || (wgm >= 4'h8 && wgm <= 4'hB);
    fast_pwm = (wgm >= 4'h5 && wgm <= 4'h7) || (wgm == 4'hE) || (wgm == 4'hF);
    // Reserved mode 13 behaves as free running
    clear_at_top = (wgm != 4'h0) && (wgm != 4'hD);
    if (icr_top) begin
      top_val = icr_r;
    end else if (ocra_top) begin
      top_val = ocra_r;
    end else if (wgm[1:0] == 2'h1) begin
      top_val = tmcap_pkg::TOP_8BIT;
    end else if (wgm[1:0] == 2'h2) begin
      top_val = tmcap_pkg::TOP_9BIT;
    end else if (wgm[1:0] == 2'h3) begin
      top_val = tmcap_pkg::TOP_10BIT;
    end else begin
      top_val = tmcap_pkg::CNT_MAX;
    end
  end

  // ********************************
  // Tick selection
  // ********************************
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_d_r;
  logic tick;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_d_r <= 1'b0;
    end else begin
      ext_s1_r <= external_clock_pin;
      ext_s2_r <= ext_s1_r;
      ext_d_r <= ext_s2_r;
    end
  end

  always_comb begin
    tick = 1'b0;
    if (cs == tmcap_pkg::CS_SYS) begin
      tick = 1'b1;
    end else if (cs >= tmcap_pkg::CS_PRE_FIRST && cs <= tmcap_pkg::CS_PRE_LAST) begin
      tick = prescale_tick[2'(cs - tmcap_pkg::CS_PRE_FIRST)];
    end else if (cs == tmcap_pkg::CS_EXT_FALL) begin
      tick = ext_d_r & ~ext_s2_r;
    end else if (cs == tmcap_pkg::CS_EXT_RISE) begin
      tick = ~ext_d_r & ext_s2_r;
    end
  end

  // ********************************
  // Counter
  // ********************************
  logic cnt_wr;
  logic ovf_evt;

  assign cnt_wr = wr_done && (apb_req.paddr == tmcap_pkg::OFS_CNT_LO);

  always_comb begin
    cnt_nxt = cnt_r;
    down_nxt = down_r;
    ovf_evt = 1'b0;
    if (cnt_wr) begin
      cnt_nxt = {temp_r, wbyte};
    end else if (tick) begin
      if (dual_slope) begin
        if (!down_r) begin
          if (cnt_r >= top_val) begin
            down_nxt = 1'b1;
            cnt_nxt = cnt_r - 16'h0001;
          end else begin
            cnt_nxt = cnt_r + 16'h0001;
          end
        end else if (cnt_r == 16'h0000) begin
          down_nxt = 1'b0;
          cnt_nxt = 16'h0001;
          ovf_evt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end else begin
        down_nxt = 1'b0;
        if (clear_at_top && cnt_r == top_val) begin
          cnt_nxt = 16'h0000;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
        // Fast PWM overflows at top, free running and clear-on-match at max
        ovf_evt = fast_pwm ? (cnt_r == top_val) : (cnt_r == tmcap_pkg::CNT_MAX);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_r <= 16'h0000;
      down_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      down_r <= down_nxt;
    end
  end

  // ********************************
  // Capture input path
  // ********************************
  logic pin_s1_r;
  logic pin_s2_r;
  logic cmp_s1_r;
  logic cmp_s2_r;
  logic cap_src;
  logic [FILTER_LEN-2:0] filt_sh_r;
  logic [FILTER_LEN-1:0] filt_win;
  logic filt_r;
  logic cap_in;
  logic cap_d_r;
  logic cap_evt;

  // Pin level includes whatever the port drives, so software can capture
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= capture_pin;
      pin_s2_r <= pin_s1_r;
      cmp_s1_r <= comparator_output;
      cmp_s2_r <= cmp_s1_r;
    end
  end

  // Source switch can itself look like an edge
  assign cap_src = comp_sel_r ? cmp_s2_r : pin_s2_r;

  // Window holds the live sample, so the filter adds exactly FILTER_LEN cycles
  assign filt_win = {filt_sh_r, cap_src};

  // Filter runs on the system clock regardless of tick selection
  always_ff @(posedge clk) begin
    if (!resetn) begin
      filt_sh_r <= '0;
      filt_r <= 1'b0;
    end else begin
      filt_sh_r <= filt_win[FILTER_LEN-2:0];
      if (&filt_win) begin
        filt_r <= 1'b1;
      end else if (~|filt_win) begin
        filt_r <= 1'b0;
      end
    end
  end

  assign cap_in = ctrl_b_r[tmcap_pkg::NOISE_EN_BIT] ? filt_r : cap_src;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cap_d_r <= 1'b0;
    end else begin
      cap_d_r <= cap_in;
    end
  end

  assign cap_evt = ~icr_top && (ctrl_b_r[tmcap_pkg::EDGE_SEL_BIT] ?
                   (cap_in & ~cap_d_r) : (~cap_in & cap_d_r));

  // Capture register: event overwrites, writes only when it is the top
  always_ff @(posedge clk) begin
    if (!resetn) begin
      icr_r <= 16'h0000;
    end else if (cap_evt) begin
      icr_r <= cnt_r;
    end else if (icr_top && wr_done && apb_req.paddr == tmcap_pkg::OFS_CAP_LO) begin
      icr_r <= {temp_r, wbyte};
    end
  end

  // ********************************
  // Flags and interrupt requests
  // ********************************
  logic flag_wr;

  assign flag_wr = wr_done && (apb_req.paddr == tmcap_pkg::OFS_FLAGS);

  // Set wins over write-one clear and service acknowledge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ovf_flag_r <= 1'b0;
      cap_flag_r <= 1'b0;
    end else begin
      ovf_flag_r <= ovf_evt | (ovf_flag_r & ~overflow_irq_ack &
                    ~(flag_wr & wbyte[tmcap_pkg::FLAG_OVF_BIT]));
      cap_flag_r <= cap_evt | (cap_flag_r & ~capture_irq_ack &
                    ~(flag_wr & wbyte[tmcap_pkg::FLAG_CAP_BIT]));
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      overflow_irq <= 1'b0;
      capture_irq <= 1'b0;
    end else begin
      overflow_irq <= ovf_flag_r & ovf_en_r;
      capture_irq <= cap_flag_r & cap_en_r;
    end
  end

  // ********************************
  // Status outputs to compare units
  // ********************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      timer_tick <= 1'b0;
      counter_top <= 1'b0;
      counter_bottom <= 1'b0;
      waveform_mode_field <= 4'h0;
      counter_value <= 16'h0000;
    end else begin
      timer_tick <= tick;
      counter_top <= (cnt_nxt == top_val);
      counter_bottom <= (cnt_nxt == 16'h0000);
      waveform_mode_field <= wgm;
      counter_value <= cnt_nxt;
    end
  end

endmodule

// *** tb/tmcap_cpu_model.sv ***
// CPU side model: APB master tasks that drive the timer block
`timescale 1ns/100ps
module tmcap_cpu_model (
  input wire logic clk,
  output tmcap_pkg::tmcap_apb_req_t apb_req,
  input wire tmcap_pkg::tmcap_apb_rsp_t apb_rsp,
  output logic hang
);
  logic [31:0] rdata;
  logic err;
  logic [15:0] v;
  initial begin
    apb_req = '0;
    hang = 1'b0;
  end
  // ****
  // Transfers
  // ****
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= a;
    apb_req.pwdata <= {24'h000000, d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 16);
    if (apb_rsp.pready !== 1'b1) hang <= 1'b1;
    rdata = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    // Released lines must not keep looking valid
    apb_req.paddr <= ~a;
    apb_req.pwdata <= ~apb_req.pwdata;
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    xfer(1'b1, a + 8'h04, d[15:8]);
    xfer(1'b1, a, d[7:0]);
  endtask
  task automatic rd16(input logic [7:0] a);
    xfer(1'b0, a, 8'h00);
    v[7:0] = rdata[7:0];
    xfer(1'b0, a + 8'h04, 8'h00);
    v[15:8] = rdata[7:0];
  endtask
endmodule

// *** tb/tmcap_assertions.sv ***
// Port-level checker of the timer counter and capture block
`timescale 1ns/100ps
module tmcap_assertions #(
  parameter int FILTER_LEN = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire tmcap_pkg::tmcap_apb_req_t apb_req,
  input wire tmcap_pkg::tmcap_apb_rsp_t apb_rsp,
  input wire logic overflow_irq,
  input wire logic capture_irq,
  input wire logic timer_tick,
  input wire logic counter_top,
  input wire logic counter_bottom,
  input wire logic [3:0] waveform_mode_field,
  input wire logic [15:0] counter_value
);
  // ****
  // Shadow of bus writes
  // ****
  logic acc;
  logic [2:0] cs_r;
  logic [1:0] ien_r;
  logic [7:0] hi_r;
  logic fresh_r;
  assign acc = apb_req.psel & apb_req.penable & apb_rsp.pready;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cs_r <= 3'h0;
      ien_r <= 2'h0;
    end else if (acc && apb_req.pwrite && apb_req.paddr == tmcap_pkg::OFS_CTRL_B) begin
      cs_r <= apb_req.pwdata[2:0];
    end else if (acc && apb_req.pwrite && apb_req.paddr == tmcap_pkg::OFS_IRQ_EN) begin
      ien_r <= apb_req.pwdata[1:0];
    end
  end
  // High byte trusted only right after a counter high write
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hi_r <= 8'h00;
      fresh_r <= 1'b0;
    end else if (acc) begin
      hi_r <= apb_req.pwdata[7:0];
      fresh_r <= apb_req.pwrite && apb_req.paddr == tmcap_pkg::OFS_CNT_HI;
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_PREADY_NEXT: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("pready missing after setup");
  AST_SLVERR_MAP: assert property (acc |-> apb_rsp.pslverr ==
    (apb_req.paddr > 8'h28 || apb_req.paddr[1:0] != 2'h0))
    else $error("pslverr wrong for address");
  AST_CNT_LOAD: assert property (acc && apb_req.pwrite && fresh_r
    && apb_req.paddr == tmcap_pkg::OFS_CNT_LO |=> counter_value
    == {$past(hi_r), 8'($past(apb_req.pwdata))})
    else $error("counter not loaded from latch and low byte");
  AST_BOTTOM: assert property ($past(resetn) |-> counter_bottom == (counter_value == 16'h0000))
    else $error("bottom indication wrong");
  AST_TOP_8BIT: assert property (waveform_mode_field == 4'h5 && counter_value == 16'h00FF
    |-> counter_top)
    else $error("top missing at 8-bit top");
  AST_NO_TICK_STOPPED: assert property ((cs_r == 3'h0) [*4] |-> !timer_tick)
    else $error("tick while stopped");
  AST_CNT_HELD: assert property ((cs_r == 3'h0 && !acc) [*4] |-> $stable(counter_value))
    else $error("counter moved while stopped");
  AST_CAP_IRQ_EN: assert property (capture_irq |-> $past(ien_r) inside {2'h2, 2'h3})
    else $error("capture irq while disabled");
  AST_OVF_IRQ_EN: assert property (overflow_irq |-> $past(ien_r) inside {2'h1, 2'h3})
    else $error("overflow irq while disabled");
endmodule

bind tmcap_top tmcap_assertions #(.FILTER_LEN(FILTER_LEN)) chk_u (
  .clk(clk), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .overflow_irq(overflow_irq), .capture_irq(capture_irq), .timer_tick(timer_tick),
  .counter_top(counter_top), .counter_bottom(counter_bottom),
  .waveform_mode_field(waveform_mode_field), .counter_value(counter_value)
);

// *** tb/tb_timer16_counter_input_capture.sv ***
// Self-checking bench of the timer counter and capture block
`timescale 1ns/100ps
module tb_timer16_counter_input_capture;
  logic clk;
  logic resetn;
  tmcap_pkg::tmcap_apb_req_t apb_req;
  tmcap_pkg::tmcap_apb_rsp_t apb_rsp;
  logic [3:0] prescale_tick;
  logic ext_pin, cap_pin, comp_out, ovf_ack, cap_ack, ovf_irq, cap_irq, hang;
  logic [3:0] mode;
  logic [15:0] cnt;
  int miscompares;
  int checks_done;
  tmcap_top dut_u (
    .clk(clk), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .prescale_tick(prescale_tick), .external_clock_pin(ext_pin), .capture_pin(cap_pin),
    .comparator_output(comp_out), .overflow_irq_ack(ovf_ack), .capture_irq_ack(cap_ack),
    .overflow_irq(ovf_irq), .capture_irq(cap_irq), .timer_tick(), .counter_top(),
    .counter_bottom(), .waveform_mode_field(mode), .counter_value(cnt)
  );
  tmcap_cpu_model cpu_u (.clk(clk), .apb_req(apb_req), .apb_rsp(apb_rsp), .hang(hang));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ****
  // Helpers
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu_u.xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    cpu_u.xfer(1'b0, a, 8'h00);
    chk(cpu_u.rdata[15:0], {8'h00, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Wrong-source pulses come first so a leaky select miscounts
  task automatic tick(input int cs);
    logic [3:0] sel;
    sel = (cs < 6) ? 4'h1 << (cs - 2) : 4'h0;
    @(posedge clk);
    prescale_tick <= 4'hF ^ sel;
    ext_pin <= 1'b1;
    @(posedge clk);
    prescale_tick <= sel;
    @(posedge clk);
    prescale_tick <= 4'h0;
    cyc(4);
    ext_pin <= 1'b0;
    cyc(4);
  endtask
  always @(posedge hang) begin
    miscompares++;
    final_report();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    resetn = 1'b0;
    prescale_tick = 4'h0;
    {ext_pin, cap_pin, comp_out, ovf_ack, cap_ack} = 5'h00;
    checks_done = 0;
    miscompares = 0;
    cyc(6);
    resetn <= 1'b1;
    rdc(tmcap_pkg::OFS_CTRL_B, 8'h00);
    rdc(tmcap_pkg::OFS_FLAGS, 8'h00);
    cpu_u.xfer(1'b0, 8'h30, 8'h00);
    chk({15'h0, cpu_u.err}, 16'h0001);
    chk(cpu_u.rdata[15:0], 16'h0000);
    cpu_u.wr16(tmcap_pkg::OFS_CNT_LO, 16'h1234);
    cyc(8);
    rdc(tmcap_pkg::OFS_CNT_LO, 8'h34);
    rdc(tmcap_pkg::OFS_CAP_HI, 8'h12);
    chk(cnt, 16'h1234);
    for (int cs = 2; cs < 8; cs++) begin
      cpu_u.wr16(tmcap_pkg::OFS_CNT_LO, 16'h0000);
      wr(tmcap_pkg::OFS_CTRL_B, {5'h00, cs[2:0]});
      repeat (3) tick(cs);
      wr(tmcap_pkg::OFS_CTRL_B, 8'h00);
      cpu_u.rd16(tmcap_pkg::OFS_CNT_LO);
      chk(cpu_u.v, 16'h0003);
    end
    cpu_u.wr16(tmcap_pkg::OFS_CNT_LO, 16'hFFFD);
    wr(tmcap_pkg::OFS_IRQ_EN, 8'h01);
    wr(tmcap_pkg::OFS_CTRL_B, 8'h01);
    cyc(6);
    wr(tmcap_pkg::OFS_CTRL_B, 8'h00);
    rdc(tmcap_pkg::OFS_FLAGS, 8'h01);
    chk({15'h0, ovf_irq}, 16'h0001);
    ovf_ack <= 1'b1;
    @(posedge clk);
    ovf_ack <= 1'b0;
    cyc(3);
    chk({15'h0, ovf_irq}, 16'h0000);
    wr(tmcap_pkg::OFS_CTRL_A, 8'h01);
    cpu_u.wr16(tmcap_pkg::OFS_CNT_LO, 16'h00FC);
    wr(tmcap_pkg::OFS_CTRL_B, 8'h09);
    cyc(4);
    cpu_u.wr16(tmcap_pkg::OFS_CNT_LO, 16'h0010);
    wr(tmcap_pkg::OFS_CTRL_B, 8'h08);
    chk({12'h000, mode}, 16'h0005);
    cpu_u.rd16(tmcap_pkg::OFS_CNT_LO);
    chk({4'h0, cpu_u.v[15:4]}, 16'h0001);
    rdc(tmcap_pkg::OFS_FLAGS, 8'h01);
    wr(tmcap_pkg::OFS_FLAGS, 8'h01);
    rdc(tmcap_pkg::OFS_FLAGS, 8'h00);
    wr(tmcap_pkg::OFS_CTRL_A, 8'h00);
    cpu_u.wr16(tmcap_pkg::OFS_CNT_LO, 16'h0ABC);
    wr(tmcap_pkg::OFS_IRQ_EN, 8'h02);
    wr(tmcap_pkg::OFS_CTRL_B, 8'h40);
    cap_pin <= 1'b1;
    cyc(6);
    chk({15'h0, cap_irq}, 16'h0001);
    rdc(tmcap_pkg::OFS_FLAGS, 8'h02);
    cpu_u.rd16(tmcap_pkg::OFS_CAP_LO);
    chk(cpu_u.v, 16'h0ABC);
    wr(tmcap_pkg::OFS_CTRL_B, 8'h00);
    cap_ack <= 1'b1;
    @(posedge clk);
    cap_ack <= 1'b0;
    cyc(3);
    chk({15'h0, cap_irq}, 16'h0000);
    cpu_u.wr16(tmcap_pkg::OFS_CNT_LO, 16'h0BCD);
    cap_pin <= 1'b0;
    cyc(6);
    cpu_u.rd16(tmcap_pkg::OFS_CAP_LO);
    chk(cpu_u.v, 16'h0BCD);
    wr(tmcap_pkg::OFS_COMP_CTRL, 8'h01);
    wr(tmcap_pkg::OFS_FLAGS, 8'h02);
    wr(tmcap_pkg::OFS_CTRL_B, 8'h40);
    cap_pin <= 1'b1;
    cyc(6);
    rdc(tmcap_pkg::OFS_FLAGS, 8'h00);
    comp_out <= 1'b1;
    cyc(6);
    rdc(tmcap_pkg::OFS_FLAGS, 8'h02);
    wr(tmcap_pkg::OFS_COMP_CTRL, 8'h00);
    wr(tmcap_pkg::OFS_FLAGS, 8'h02);
    wr(tmcap_pkg::OFS_CTRL_B, 8'hC0);
    cap_pin <= 1'b0;
    cyc(10);
    cap_pin <= 1'b1;
    cyc(3);
    cap_pin <= 1'b0;
    cyc(10);
    rdc(tmcap_pkg::OFS_FLAGS, 8'h00);
    cap_pin <= 1'b1;
    cyc(8);
    chk({15'h0, cap_irq}, 16'h0000);
    cyc(1);
    chk({15'h0, cap_irq}, 16'h0001);
    wr(tmcap_pkg::OFS_FLAGS, 8'h02);
    wr(tmcap_pkg::OFS_CTRL_B, 8'h40);
    cpu_u.wr16(tmcap_pkg::OFS_CAP_LO, 16'h55AA);
    cpu_u.rd16(tmcap_pkg::OFS_CAP_LO);
    chk(cpu_u.v, 16'h0BCD);
    wr(tmcap_pkg::OFS_CTRL_B, 8'h58);
    cpu_u.wr16(tmcap_pkg::OFS_CAP_LO, 16'h0300);
    cpu_u.rd16(tmcap_pkg::OFS_CAP_LO);
    chk(cpu_u.v, 16'h0300);
    chk({12'h000, mode}, 16'h000C);
    cap_pin <= 1'b0;
    cyc(6);
    cap_pin <= 1'b1;
    cyc(6);
    rdc(tmcap_pkg::OFS_FLAGS, 8'h00);
    final_report();
  end
endmodule
